//--- efsu_defs.svh
// Register offsets, bit positions and reset values of the event flag unit.
// Included by the design files; holds definitions only.
`ifndef EFSU_DEFS_SVH
`define EFSU_DEFS_SVH

// Serial register offsets
`define EFSU_ADDR_ENABLE_PRIMARY     8'h12
`define EFSU_ADDR_ENABLE_SECONDARY   8'h13
`define EFSU_ADDR_FLAGS_PRIMARY      8'h15
`define EFSU_ADDR_FLAGS_SECONDARY    8'h16
`define EFSU_ADDR_STATUS_VOLTAGE     8'h17
`define EFSU_ADDR_STATUS_TEMPERATURE 8'h18

// Reset values
`define EFSU_RST_ENABLE_PRIMARY      8'h01
`define EFSU_RST_ENABLE_SECONDARY    8'h00
`define EFSU_RST_FLAGS_PRIMARY       8'h01
`define EFSU_RST_FLAGS_SECONDARY     8'h00

// Writable bits; bit 7 of the primary enable register is reserved
`define EFSU_MASK_ENABLE_PRIMARY     8'h7f
`define EFSU_MASK_ENABLE_SECONDARY   8'hff

// Primary flag bit positions
`define EFSU_BIT_SERIAL_READY        0
`define EFSU_BIT_OVERDISCHARGE       1
`define EFSU_BIT_STORAGE_READY       2
`define EFSU_BIT_OVERCHARGE          3
`define EFSU_BIT_SOURCES_LOW         4
`define EFSU_BIT_CHARGE_TEMP         5
`define EFSU_BIT_DISCHARGE_TEMP      6

// Level vector positions: analog levels, then the two serial pins (synchronised inputs)
`define EFSU_LVL_OVERDISCHARGE       0
`define EFSU_LVL_READY               1
`define EFSU_LVL_OVERCHARGE          2
`define EFSU_LVL_SRC1_BELOW          3
`define EFSU_LVL_SRC2_BELOW          4
`define EFSU_LVL_CHARGE_COLD         5
`define EFSU_LVL_CHARGE_HOT          6
`define EFSU_LVL_DISCHARGE_COLD      7
`define EFSU_LVL_DISCHARGE_HOT       8
`define EFSU_LVL_SCL                 9
`define EFSU_LVL_SDA                 10
`define EFSU_LVL_COUNT               11

// Serial engine counts
`define EFSU_BITS_PER_BYTE           4'd8
`define EFSU_DEV_ADDR_DEFAULT        7'h2a

`endif

//--- efsu_pkg.sv
// Types shared by the event flag unit: serial engine states and state record.
// Assumes nothing beyond a SystemVerilog compiler.
package efsu_pkg;

	// Serial engine states, one-hot
	typedef enum logic [6:0] {
		EFSU_IDLE  = 7'b0000001,
		EFSU_ADDR  = 7'b0000010,
		EFSU_ACK_A = 7'b0000100,
		EFSU_WRITE = 7'b0001000,
		EFSU_ACK_W = 7'b0010000,
		EFSU_READ  = 7'b0100000,
		EFSU_ACK_R = 7'b1000000
	} efsu_state_t;

	// Whole state of the top module
	typedef struct packed {
		efsu_state_t state;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic [7:0]  ptr;
		logic        first;
		logic        rw;
		logic        scl_q;
		logic        sda_q;
		logic [8:0]  lvl_q;
		logic [7:0]  en0;
		logic [7:0]  en1;
		logic [7:0]  clr0;
		logic [7:0]  clr1;
		logic        sda_out;
		logic        sda_oe_n;
		logic        irq;
	} efsu_top_state_t;

endpackage

//--- efsu_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit may change at any time relative to clk_sys.
`timescale 1ns/1ps
module efsu_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second; nothing else looks at it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

//--- efsu_flag_bank.sv
// Eight sticky event flags gated by enables, cleared by a read mask.
// Assumes set and clear arrive as one-cycle pulses on clk_sys.
`timescale 1ns/1ps
module efsu_flag_bank #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] VALID_MASK  = 8'hff
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Events and control
	input  wire logic [7:0] event_pulse,
	input  wire logic [7:0] enable,
	input  wire logic [7:0] clear_mask,
	// Flags
	output logic      [7:0] flags
);
	genvar i;

	// Set wins over clear, so an event in the read cycle is kept
	generate
		for (i = 0; i < 8; i++) begin : g_flag
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					flags[i] <= RESET_VALUE[i];
				end else if (!VALID_MASK[i]) begin
					flags[i] <= 1'b0;
				end else if (event_pulse[i] && enable[i]) begin
					flags[i] <= 1'b1;
				end else if (clear_mask[i]) begin
					flags[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule

//--- efsu_top.sv
// Event flag and status unit of a dual-source energy manager.
// Assumes analog levels and the serial pins are asynchronous to clk_sys,
// and that done/start/error/ready events are one-cycle pulses on clk_sys.
//
// What this block does
// - Enabled event sets flag, raises interrupt pin
// - Flag and pin hold until flag read
// - Serial-enabled flags survive return to strap mode
// - Primary bit 6: discharge temperature limit crossed
// - Primary bit 5: charge temperature limit crossed
// - Primary bit 4: both sources cross low threshold
// - Primary bit 3: storage crosses overcharge threshold
// - Primary bit 2: storage crosses ready threshold
// - Primary bit 1: storage crosses overdischarge threshold
// - Primary bit 0: serial ready; resets to one
// - Secondary bit 7: buck power monitor error
// - Secondary bit 6: new average power data
// - Secondary bit 5: temperature conversion done
// - Secondary bit 4: storage conversion done
// - Secondary bits 3,2: source two tracking done/start
// - Secondary bits 1,0: source one tracking done/start
// - Voltage status bits 4,3: sources below floor
// - Status bit 2: storage above overcharge
// - Status bit 1: storage above ready
// - Status bit 0: storage below overdischarge
// - Temperature bits 3,1: above hot limits
// - Temperature bits 2,0: below cold limits
// - Enable registers gate each flag bitwise
`timescale 1ns/1ps
`include "efsu_defs.svh"
module efsu_top #(
	parameter logic [6:0] DEV_ADDR = `EFSU_DEV_ADDR_DEFAULT
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Serial pins, open drain
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	// Interrupt pin, high while any flag is set
	output logic      irq,
	// Analog comparator levels, asynchronous
	input  wire logic overdischarge_below,
	input  wire logic storage_ready_above,
	input  wire logic overcharge_above,
	input  wire logic first_source_below,
	input  wire logic second_source_below,
	input  wire logic charge_cold_level,
	input  wire logic charge_hot_level,
	input  wire logic discharge_cold_level,
	input  wire logic discharge_hot_level,
	// Event pulses from on-chip logic
	input  wire logic serial_ready_event,
	input  wire logic power_monitor_error_event,
	input  wire logic power_data_ready_event,
	input  wire logic thermal_conversion_done,
	input  wire logic storage_conversion_done,
	input  wire logic second_tracking_done,
	input  wire logic second_tracking_begin,
	input  wire logic first_tracking_done,
	input  wire logic first_tracking_begin
);
	import efsu_pkg::*;

	efsu_top_state_t cur;
	efsu_top_state_t next_cur;

	logic [`EFSU_LVL_COUNT-1:0] async_lvl;
	logic [`EFSU_LVL_COUNT-1:0] lvl;
	logic [7:0] flags0;
	logic [7:0] flags1;
	logic [7:0] evt0;
	logic [7:0] evt1;
	logic [8:0] lvl_chg;
	logic [7:0] level_status_voltage;
	logic [7:0] level_status_temperature;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;

	// Bus pins enter inverted: a cleared synchroniser then reads idle high
	assign async_lvl = {~sda_in, ~scl_in,
		discharge_hot_level, discharge_cold_level,
		charge_hot_level, charge_cold_level,
		second_source_below, first_source_below,
		overcharge_above, storage_ready_above, overdischarge_below};

	efsu_sync #(
		.WIDTH(`EFSU_LVL_COUNT)
	) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.async_in(async_lvl),
		.sync_out(lvl)
	);

	// Serial bus edges and framing conditions
	assign scl_s    = ~lvl[`EFSU_LVL_SCL];
	assign sda_s    = ~lvl[`EFSU_LVL_SDA];
	assign scl_rise = scl_s & ~cur.scl_q;
	assign scl_fall = ~scl_s & cur.scl_q;
	assign start_c  = scl_s & cur.scl_q & cur.sda_q & ~sda_s;
	assign stop_c   = scl_s & cur.scl_q & ~cur.sda_q & sda_s;

	// Any change of a comparator level counts as a crossing
	assign lvl_chg = lvl[8:0] ^ cur.lvl_q;

	// Primary events; bit 7 is reserved and never fires
	always_comb begin
		evt0 = 8'h00;
		evt0[`EFSU_BIT_SERIAL_READY]   = serial_ready_event;
		evt0[`EFSU_BIT_OVERDISCHARGE]  =
			lvl_chg[`EFSU_LVL_OVERDISCHARGE];
		evt0[`EFSU_BIT_STORAGE_READY]  = lvl_chg[`EFSU_LVL_READY];
		evt0[`EFSU_BIT_OVERCHARGE]     = lvl_chg[`EFSU_LVL_OVERCHARGE];
		// Only the joint condition of both sources matters here
		evt0[`EFSU_BIT_SOURCES_LOW]    =
			(lvl[`EFSU_LVL_SRC1_BELOW] & lvl[`EFSU_LVL_SRC2_BELOW]) !=
			(cur.lvl_q[`EFSU_LVL_SRC1_BELOW] &
			 cur.lvl_q[`EFSU_LVL_SRC2_BELOW]);
		evt0[`EFSU_BIT_CHARGE_TEMP]    = lvl_chg[`EFSU_LVL_CHARGE_COLD] |
			lvl_chg[`EFSU_LVL_CHARGE_HOT];
		evt0[`EFSU_BIT_DISCHARGE_TEMP] = lvl_chg[`EFSU_LVL_DISCHARGE_COLD] |
			lvl_chg[`EFSU_LVL_DISCHARGE_HOT];
	end

	// Secondary events, one per bit from on-chip pulses
	assign evt1 = {power_monitor_error_event,
		power_data_ready_event,
		thermal_conversion_done,
		storage_conversion_done,
		second_tracking_done, second_tracking_begin,
		first_tracking_done, first_tracking_begin};

	// Enables live in serial registers only, so no strap mode touches them
	efsu_flag_bank #(
		.RESET_VALUE(`EFSU_RST_FLAGS_PRIMARY),
		.VALID_MASK (`EFSU_MASK_ENABLE_PRIMARY)
	) u_flags0 (
		.clk_sys    (clk_sys),
		.resetn     (resetn),
		.event_pulse(evt0),
		.enable     (cur.en0),
		.clear_mask (cur.clr0),
		.flags      (flags0)
	);

	efsu_flag_bank #(
		.RESET_VALUE(`EFSU_RST_FLAGS_SECONDARY),
		.VALID_MASK (`EFSU_MASK_ENABLE_SECONDARY)
	) u_flags1 (
		.clk_sys    (clk_sys),
		.resetn     (resetn),
		.event_pulse(evt1),
		.enable     (cur.en1),
		.clear_mask (cur.clr1),
		.flags      (flags1)
	);

	// Live levels; reserved bits tied low
	assign level_status_voltage = {3'h0,
		lvl[`EFSU_LVL_SRC2_BELOW], lvl[`EFSU_LVL_SRC1_BELOW],
		lvl[`EFSU_LVL_OVERCHARGE],
		lvl[`EFSU_LVL_READY],
		lvl[`EFSU_LVL_OVERDISCHARGE]};
	assign level_status_temperature = {4'h0,
		lvl[`EFSU_LVL_DISCHARGE_HOT],
		lvl[`EFSU_LVL_DISCHARGE_COLD],
		lvl[`EFSU_LVL_CHARGE_HOT],
		lvl[`EFSU_LVL_CHARGE_COLD]};

	// Register read multiplexer; unmapped offsets read zero
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`EFSU_ADDR_ENABLE_PRIMARY:     v = cur.en0;
			`EFSU_ADDR_ENABLE_SECONDARY:   v = cur.en1;
			`EFSU_ADDR_FLAGS_PRIMARY:      v = flags0;
			`EFSU_ADDR_FLAGS_SECONDARY:    v = flags1;
			`EFSU_ADDR_STATUS_VOLTAGE:     v = level_status_voltage;
			`EFSU_ADDR_STATUS_TEMPERATURE: v = level_status_temperature;
			default:                       v = 8'h00;
		endcase
		return v;
	endfunction

	// Serial engine, register writes and read-side clear masks
	always_comb begin
		logic [7:0] rdata;
		rdata = rd_mux(cur.ptr);
		next_cur = cur;
		next_cur.scl_q   = scl_s;
		next_cur.sda_q   = sda_s;
		next_cur.lvl_q   = lvl[8:0];
		next_cur.clr0    = 8'h00;
		next_cur.clr1    = 8'h00;
		next_cur.sda_out = 1'b0;
		// Interrupt follows the sticky flags; reserved bits are held low
		next_cur.irq = |flags0 | |flags1;

		if (start_c) begin
			next_cur.state    = EFSU_ADDR;
			next_cur.bitcnt   = 4'd0;
			next_cur.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			next_cur.state    = EFSU_IDLE;
			next_cur.sda_oe_n = 1'b1;
		end else begin
			case (cur.state)
				EFSU_IDLE: begin
					next_cur.sda_oe_n = 1'b1;
				end
				EFSU_ADDR, EFSU_WRITE: begin
					if (scl_rise) begin
						next_cur.shreg  = {cur.shreg[6:0], sda_s};
						next_cur.bitcnt = cur.bitcnt + 4'd1;
					end else if (scl_fall &&
						cur.bitcnt == `EFSU_BITS_PER_BYTE) begin
						if (cur.state == EFSU_ADDR) begin
							// Foreign address: stay off the bus until the stop
							if (cur.shreg[7:1] == DEV_ADDR) begin
								next_cur.rw       = cur.shreg[0];
								next_cur.state    = EFSU_ACK_A;
								next_cur.sda_oe_n = 1'b0;
							end else begin
								next_cur.state = EFSU_IDLE;
							end
						end else begin
							next_cur.state    = EFSU_ACK_W;
							next_cur.sda_oe_n = 1'b0;
							if (cur.first) begin
								next_cur.ptr   = cur.shreg;
								next_cur.first = 1'b0;
							end else begin
								// Only the enables take writes
								if (cur.ptr == `EFSU_ADDR_ENABLE_PRIMARY) begin
									next_cur.en0 = cur.shreg &
										`EFSU_MASK_ENABLE_PRIMARY;
								end
								if (cur.ptr == `EFSU_ADDR_ENABLE_SECONDARY) begin
									next_cur.en1 = cur.shreg &
										`EFSU_MASK_ENABLE_SECONDARY;
								end
								next_cur.ptr = cur.ptr + 8'd1;
							end
						end
					end
				end
				EFSU_ACK_A: begin
					if (scl_fall) begin
						next_cur.bitcnt = 4'd0;
						if (cur.rw) begin
							next_cur.state = EFSU_READ;
							next_cur.shreg = rdata;
							next_cur.sda_oe_n = rdata[7];
							next_cur.ptr = cur.ptr + 8'd1;
							// Clear only what was captured for the host
							if (cur.ptr == `EFSU_ADDR_FLAGS_PRIMARY) begin
								next_cur.clr0 = rdata;
							end
							if (cur.ptr == `EFSU_ADDR_FLAGS_SECONDARY) begin
								next_cur.clr1 = rdata;
							end
						end else begin
							next_cur.state    = EFSU_WRITE;
							next_cur.first    = 1'b1;
							next_cur.sda_oe_n = 1'b1;
						end
					end
				end
				EFSU_ACK_W: begin
					if (scl_fall) begin
						next_cur.state    = EFSU_WRITE;
						next_cur.bitcnt   = 4'd0;
						next_cur.sda_oe_n = 1'b1;
					end
				end
				EFSU_READ: begin
					if (scl_rise) begin
						next_cur.bitcnt = cur.bitcnt + 4'd1;
					end else if (scl_fall) begin
						if (cur.bitcnt == `EFSU_BITS_PER_BYTE) begin
							next_cur.state    = EFSU_ACK_R;
							next_cur.sda_oe_n = 1'b1;
						end else begin
							next_cur.shreg    = {cur.shreg[6:0], 1'b0};
							next_cur.sda_oe_n = cur.shreg[6];
						end
					end
				end
				EFSU_ACK_R: begin
					// A host nack ends the read; wait for the stop
					if (scl_rise) begin
						next_cur.rw = ~sda_s;
					end else if (scl_fall) begin
						next_cur.bitcnt = 4'd0;
						if (cur.rw) begin
							next_cur.state = EFSU_READ;
							next_cur.shreg = rdata;
							next_cur.sda_oe_n = rdata[7];
							next_cur.ptr = cur.ptr + 8'd1;
							if (cur.ptr == `EFSU_ADDR_FLAGS_PRIMARY) begin
								next_cur.clr0 = rdata;
							end
							if (cur.ptr == `EFSU_ADDR_FLAGS_SECONDARY) begin
								next_cur.clr1 = rdata;
							end
						end else begin
							next_cur.state = EFSU_IDLE;
						end
					end
				end
				default: begin
					next_cur.state    = EFSU_IDLE;
					next_cur.sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	// State register; the primary flag resets set, so irq comes up high
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cur          <= '0;
			cur.state    <= EFSU_IDLE;
			cur.scl_q    <= 1'b1;
			cur.sda_q    <= 1'b1;
			cur.en0      <= `EFSU_RST_ENABLE_PRIMARY;
			cur.en1      <= `EFSU_RST_ENABLE_SECONDARY;
			cur.sda_oe_n <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs straight from the state register
	assign sda_out  = cur.sda_out;
	assign sda_oe_n = cur.sda_oe_n;
	assign irq      = cur.irq;
endmodule

//--- efsu_top_monitor.sv
// Checker for the interrupt pin and the serial data pin of efsu_top.
// Assumes it is bound to efsu_top and sees only that module's ports.
`timescale 1ns/1ps
module efsu_top_monitor (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Pins
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic irq
);
	logic [7:0] hi_cnt;
	logic [7:0] lo_cnt;
	logic [7:0] fall_cnt;
	logic       scl_q;
	// Saturating step, so long idle spans never wrap round to small counts
	function automatic logic [7:0] inc(input logic [7:0] v);
		return v + {7'h00, v != 8'hff};
	endfunction
	// Cycles the clock pin has been high, low, and since it last fell
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hi_cnt   <= 8'h00;
			lo_cnt   <= 8'h00;
			fall_cnt <= 8'hff;
			scl_q    <= 1'b1;
		end else begin
			hi_cnt   <= scl_in ? inc(hi_cnt) : 8'h00;
			lo_cnt   <= scl_in ? 8'h00 : inc(lo_cnt);
			fall_cnt <= (scl_q && !scl_in) ? 8'h00 : inc(fall_cnt);
			scl_q    <= scl_in;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// A flag leaves reset set, so the pin rises at once; data pin stays off
	irq_after_reset_a: assert property (
		$rose(resetn) |-> ##[1:2] irq)
		else $error("irq low after reset");
	sda_quiet_reset_a: assert property (
		$rose(resetn) |-> sda_oe_n [*8])
		else $error("data pin driven after reset");
	// The pin only drops just after a clock fall of a flag read
	irq_fall_read_a: assert property (
		$fell(irq) |-> fall_cnt >= 8'h03 && fall_cnt <= 8'h09)
		else $error("irq dropped outside a read");
	irq_idle_hold_a: assert property (
		irq && hi_cnt > 8'h14 |=> irq)
		else $error("irq dropped on idle bus");
	// Open drain: only low is driven, and the drive only changes while the clock is low
	sda_low_only_a: assert property (
		!sda_oe_n |-> !sda_out)
		else $error("data pin driven high");
	sda_turn_time_a: assert property (
		$changed(sda_oe_n) |-> lo_cnt >= 8'h02 && lo_cnt <= 8'h06)
		else $error("data pin changed off time");
	sda_stable_high_a: assert property (
		scl_in && $past(scl_in) |-> $stable(sda_oe_n))
		else $error("data pin moved while clock high");
	sda_idle_a: assert property (
		hi_cnt > 8'h0c |-> sda_oe_n)
		else $error("data pin held on idle bus");
	// Main scenarios reached
	cover property ($rose(irq));
	cover property ($fell(irq));
	cover property ($fell(sda_oe_n));
endmodule
bind efsu_top efsu_top_monitor efsu_top_monitor_inst (
	.clk_sys, .resetn, .scl_in, .sda_out, .sda_oe_n, .irq
);

//--- efsu_host_model.sv
// Host microcontroller model: serial bus master with register tasks.
// Assumes a pull-up on the data wire and a device that only pulls low.
`timescale 1ns/1ps
module efsu_host_model #(
	parameter logic [6:0] DEV = 7'h2a
) (
	// Clock
	input  wire logic clk_sys,
	// Device data drive
	input  wire logic sda_out,
	input  wire logic sda_oe_n,
	// Pin levels seen by the device
	output logic      scl,
	output logic      sda
);
	logic       rel;
	logic [7:0] nak;
	// Pulled-up wire: low when either side pulls it down
	assign sda = rel & (sda_oe_n | sda_out);
	initial begin
		scl = 1'b1;
		rel = 1'b1;
		nak = 8'h00;
	end
	// Set both pins just after a falling edge, then hold n cycles
	task automatic pin(input logic c, input logic d, input int n);
		scl = c;
		rel = d;
		repeat (n) @(negedge clk_sys);
	endtask
	// One bit; clock high for 8 cycles, well above the device minimum
	task automatic xfer(input logic b, output logic r);
		pin(1'b0, b, 4);
		pin(1'b1, b, 4);
		r = sda;
		pin(1'b1, b, 4);
		pin(1'b0, b, 4);
	endtask
	// Start or repeated start, and stop
	task automatic st;
		pin(scl, 1'b1, 4);
		pin(1'b1, 1'b1, 8);
		pin(1'b1, 1'b0, 8);
		pin(1'b0, 1'b0, 4);
	endtask
	task automatic sp;
		pin(1'b0, 1'b0, 4);
		pin(1'b1, 1'b0, 8);
		pin(1'b1, 1'b1, 8);
	endtask
	// Byte out; a missing acknowledge is counted
	task automatic wb(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			xfer(d[i], r);
		xfer(1'b1, r);
		nak = nak + {7'h00, r};
	endtask
	// The host picks which events raise the interrupt pin
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		st();
		wb({DEV, 1'b0});
		wb(a);
		wb(d);
		sp();
	endtask
	// Pointer write, repeated start, one byte back, then no acknowledge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		logic r;
		st();
		wb({DEV, 1'b0});
		wb(a);
		st();
		wb({DEV, 1'b1});
		for (int i = 7; i >= 0; i--)
			xfer(1'b1, d[i]);
		xfer(1'b1, r);
		sp();
	endtask
endmodule

//--- efsu_top_tb.sv
// Testbench of efsu_top: event pulses, levels and register reads.
// Assumes efsu_host_model supplies the serial pins and register tasks.
`timescale 1ns/1ps
module efsu_top_tb;
	logic       clk_sys, resetn, scl_in, sda_in, sda_out, sda_oe_n, irq;
	logic [8:0] lv;
	logic [8:0] ev;
	logic [7:0] got;
	int         miscompares;
	int         comparisons;
	// 100 MHz clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	// Levels travel as a vector in level vector order, pulses as one in secondary flag bit order with serial ready at bit 8
	efsu_top efsu_top_inst (
		.clk_sys, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe_n, .irq,
		.overdischarge_below(lv[0]), .storage_ready_above(lv[1]),
		.overcharge_above(lv[2]), .first_source_below(lv[3]),
		.second_source_below(lv[4]), .charge_cold_level(lv[5]),
		.charge_hot_level(lv[6]), .discharge_cold_level(lv[7]),
		.discharge_hot_level(lv[8]), .serial_ready_event(ev[8]),
		.first_tracking_begin(ev[0]), .first_tracking_done(ev[1]),
		.second_tracking_begin(ev[2]), .second_tracking_done(ev[3]),
		.storage_conversion_done(ev[4]),
		.thermal_conversion_done(ev[5]),
		.power_data_ready_event(ev[6]),
		.power_monitor_error_event(ev[7])
	);
	efsu_host_model host (
		.clk_sys, .sda_out, .sda_oe_n, .scl(scl_in), .sda(sda_in)
	);
	task automatic hc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Compare one value; a mismatch is reported and counted
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		host.rd_reg(a, got);
		chk($sformatf("reg %h", a), exp, got);
	endtask
	task automatic complete_run;
		$display("Counts: %0d compared, %0d wrong", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Reset values, clear on read, read-only and unmapped places
	task automatic t_reset_values;
		chk("irq", 8'h01, {7'h00, irq});
		rdc(8'h15, 8'h01);
		chk("irq", 8'h00, {7'h00, irq});
		rdc(8'h15, 8'h00);
		rdc(8'h16, 8'h00);
		host.wr_reg(8'h17, 8'hff);
		rdc(8'h17, 8'h00);
		rdc(8'h18, 8'h00);
		rdc(8'h30, 8'h00);
	endtask
	// Pulses are ignored while gated off, then each sets its own flag
	task automatic t_events;
		logic [7:0] a;
		logic [7:0] e;
		host.wr_reg(8'h13, 8'h00);
		ev[7:0] = 8'hff;
		hc(1);
		ev[7:0] = 8'h00;
		hc(8);
		chk("irq", 8'h00, {7'h00, irq});
		rdc(8'h16, 8'h00);
		host.wr_reg(8'h13, 8'hff);
		for (int i = 0; i < 9; i++) begin
			a = (i < 8) ? 8'h16 : 8'h15;
			e = (i < 8) ? (8'h01 << i) : 8'h01;
			ev[i] = 1'b1;
			hc(1);
			ev[i] = 1'b0;
			hc(24);
			chk("irq", 8'h01, {7'h00, irq});
			rdc(a, e);
			chk("irq", 8'h00, {7'h00, irq});
		end
	endtask
	// Levels rise one by one, then all fall together
	task automatic t_levels;
		logic [7:0] expf [0:8];
		expf = '{8'h02, 8'h04, 8'h08, 8'h00, 8'h10,
			8'h20, 8'h20, 8'h40, 8'h40};
		host.wr_reg(8'h12, 8'hff);
		rdc(8'h12, 8'h7f);
		for (int i = 0; i < 9; i++) begin
			lv[i] = 1'b1;
			hc(12);
			rdc(8'h15, expf[i]);
			rdc(8'h17, {3'h0, lv[4:0]});
			rdc(8'h18, {4'h0, lv[8:5]});
		end
		lv = 9'h000;
		hc(12);
		rdc(8'h15, 8'h7e);
		chk("acks missed", 8'h00, host.nak);
	endtask
	initial begin
		miscompares = 0;
		comparisons = 0;
		resetn = 1'b0;
		lv = 9'h000;
		ev = 9'h000;
		hc(5);
		resetn = 1'b1;
		hc(4);
		t_reset_values();
		t_events();
		t_levels();
		complete_run();
	end
	// Watchdog: the sequence needs well under half of this span
	initial begin
		#800000;
		miscompares++;
		$display("ERROR watchdog expected finish seen timeout");
		complete_run();
	end
endmodule
